// >>> design/spdif_rx_port_pkg.sv
// constants, types and helpers of the receive audio port control registers
// assumes one 8-bit register port on the system clock and a separate port clock
// What this block does
// R1: format field bits 1:0 picks dsp 11, i2s 10, left 01, right 00
// R2: bit 5 inverts frame clock, or in dsp picks sub-mode b over a
// R3: bit 6 clear makes host drive clocks; set makes device drive both while the source is present or bit 7 is set
// R4: in master mode bit 7 keeps clocks running after the source is lost
// R5: readback select 000 interrupt, 001-101 channel status, 110 spdif status
// R6: software avoids select code 111; the block returns zero for it
// R7: readback bit 3 enables continuous read-back of the selected status
// R8: readback bit 4 enables the appended-flags audio output mode
// R9: readback bit 6 clear truncates received words; set passes them whole
// R10: readback bit 7, reset high, allows 192 kHz reception, else 96 kHz
// R11: power bits 0 and 1 disable pll and receiver, both set after reset
// R12: power bit 2, reset high, disables the transmitter while set
package spdif_rx_port_pkg;

  typedef logic [6:0] addr_t;
  typedef logic [7:0] byte_t;

  localparam addr_t ADDR_RX_PORT     = 7'h1c;
  localparam addr_t ADDR_READBACK    = 7'h1d;
  localparam addr_t ADDR_POWER       = 7'h1e;
  localparam addr_t ADDR_STATUS_VIEW = 7'h1f;

  localparam byte_t RX_PORT_RESET  = 8'h06;
  localparam byte_t READBACK_RESET = 8'h80;
  localparam byte_t POWER_RESET    = 8'h07;
  localparam byte_t READBACK_MASK  = 8'hdf;
  localparam byte_t POWER_MASK     = 8'h07;

  localparam int FMT_LO        = 0;
  localparam int FMT_HI        = 1;
  localparam int POL_BIT       = 5;
  localparam int MASTER_BIT    = 6;
  localparam int KEEP_BIT      = 7;
  localparam int SEL_LO        = 0;
  localparam int SEL_HI        = 2;
  localparam int CONTINUOUS_READBACK_BIT      = 3;
  localparam int FLAGS_BIT     = 4;
  localparam int TRUNC_BIT     = 6;
  localparam int HIGH_RATE_BIT = 7;
  localparam int PLL_BIT       = 0;
  localparam int RX_PD_BIT     = 1;
  localparam int TX_PD_BIT     = 2;
  localparam int CS_COUNT      = 5;

  typedef enum logic [1:0] {
    FMT_RIGHT = 2'h0,
    FMT_LEFT  = 2'h1,
    FMT_I2S   = 2'h2,
    FMT_DSP   = 2'h3
  } port_format_t;

  typedef enum logic [2:0] {
    SEL_INT   = 3'h0,
    SEL_CS1   = 3'h1,
    SEL_CS2   = 3'h2,
    SEL_CS3   = 3'h3,
    SEL_CS4   = 3'h4,
    SEL_CS5   = 3'h5,
    SEL_SPDIF = 3'h6,
    SEL_NONE  = 3'h7
  } readback_sel_t;

  typedef logic [4:0] slot_t;
  localparam slot_t SLOT_FIRST = 5'h00;
  localparam slot_t SLOT_LAST  = 5'h1f;
  localparam slot_t SLOT_STEP  = 5'h01;

  typedef enum logic [1:0] {
    LINK_IDLE  = 2'h0,
    LINK_RUN   = 2'h1,
    LINK_DRAIN = 2'h3
  } link_state_t;

  function automatic logic is_dsp(input port_format_t fmt);
    return fmt == FMT_DSP;
  endfunction : is_dsp

  // frame clock level for a slot; idle level when the port is stopped
  function automatic logic frame_level(input port_format_t fmt, input logic pol,
                                       input logic active, input logic half,
                                       input slot_t slot);
    logic level;
    level = 1'h0;
    if (is_dsp(fmt)) begin
      if (active && pol) begin
        level = !half && (slot == SLOT_FIRST);
      end else if (active) begin
        level = half && (slot == SLOT_LAST);
      end
    end else begin
      level = active ? (half ^ pol) : pol;
    end
    return level;
  endfunction : frame_level

endpackage : spdif_rx_port_pkg

// >>> design/clock_sync.sv
// two flip-flop level synchroniser
// assumes the input changes slowly compared with the destination clock
`timescale 1ns/100ps
module clock_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clock,
  input  wire logic [WIDTH-1:0] i_data,
  output logic      [WIDTH-1:0] o_data
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_t;

  sync_state_t sync_reg;
  sync_state_t sync_next;

  always_comb begin
    sync_next        = sync_reg;
    sync_next.first  = i_data;
    sync_next.second = sync_reg.first;
  end

  always_ff @(posedge i_clock) begin
    sync_reg <= sync_next;
  end

  assign o_data = sync_reg.second;

endmodule : clock_sync

// >>> design/spdif_rx_port_regs.sv
// receive audio port, readback and power-down control registers
// with the port clock generator on the link clock
// assumes status inputs come from logic on i_clock; source detect is a pin
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
module spdif_rx_port_regs (
  input  wire logic                                    i_clock,
  input  wire logic                                    i_resetn,
  input  wire logic                                    i_link_clock,
  input  wire spdif_rx_port_pkg::addr_t                i_address,
  input  wire spdif_rx_port_pkg::byte_t                i_write_data,
  input  wire logic                                    i_write_strobe,
  input  wire logic                                    i_read_strobe,
  output spdif_rx_port_pkg::byte_t                     o_read_data,
  input  wire spdif_rx_port_pkg::byte_t                i_int_status,
  input  wire spdif_rx_port_pkg::byte_t [4:0]          i_chan_status,
  input  wire spdif_rx_port_pkg::byte_t                i_spdif_status,
  input  wire logic                                    i_source_present,
  output spdif_rx_port_pkg::port_format_t              o_rx_port_format,
  output logic                                         o_rx_frame_polarity_select,
  output logic                                         o_port_clock_master_select,
  output logic                                         o_continuous_readback,
  output logic                                         o_appended_flags_mode,
  output logic                                         o_word_trunc_mask,
  output logic                                         o_high_rate_rx_enable,
  output logic                                         o_pll_power_down,
  output logic                                         o_receiver_power_down,
  output logic                                         o_transmitter_power_down,
  output spdif_rx_port_pkg::byte_t                     o_status_view,
  output logic                                         o_port_clock_active,
  output logic                                         o_bit_clock,
  output logic                                         o_bit_clock_oe_n,
  output logic                                         o_frame_clock,
  output logic                                         o_frame_clock_oe_n
);
  import spdif_rx_port_pkg::*;

  typedef struct packed {
    byte_t rx_port;
    byte_t readback;
    byte_t power;
    byte_t read_data;
    byte_t status_hold;
    logic  snap_pending;
  } main_state_t;

  localparam main_state_t MAIN_RESET = '{
    rx_port:      RX_PORT_RESET,
    readback:     READBACK_RESET,
    power:        POWER_RESET,
    read_data:    8'h00,
    status_hold:  8'h00,
    snap_pending: 1'h0
  };

  typedef struct packed {
    link_state_t state;
    logic        bit_div;
    slot_t       slot;
    logic        half;
    logic        bit_out;
    logic        frame_out;
    logic        oe_n;
  } link_state_reg_t;

  localparam link_state_reg_t LINK_RESET = '{
    state:     LINK_IDLE,
    bit_div:   1'h0,
    slot:      SLOT_FIRST,
    half:      1'h0,
    bit_out:   1'h0,
    frame_out: 1'h0,
    oe_n:      1'h1
  };

  main_state_t     main_reg;
  main_state_t     main_next;
  link_state_reg_t link_reg;
  link_state_reg_t link_next;
  logic            link_resetn;
  logic [5:0]      cfg_sync;
  port_format_t    cfg_fmt;
  logic            cfg_pol;
  logic            cfg_master;
  logic            cfg_keep;
  logic            cfg_source;
  logic            run_ok;
  logic            link_active;
  logic            frame_end;

  // status source picked by the readback select code
  function automatic byte_t status_pick(input readback_sel_t sel, input byte_t int_s,
                                        input byte_t [CS_COUNT-1:0] cs,
                                        input byte_t spd);
    byte_t value;
    value = 8'h00;
    case (sel)
      SEL_INT:   value = int_s;
      SEL_CS1:   value = cs[0];
      SEL_CS2:   value = cs[1];
      SEL_CS3:   value = cs[2];
      SEL_CS4:   value = cs[3];
      SEL_CS5:   value = cs[4];
      SEL_SPDIF: value = spd;
      default:   value = 8'h00;
    endcase
    return value;
  endfunction : status_pick

  // register file on the system clock
  always_comb begin
    main_next              = main_reg;
    main_next.read_data    = 8'h00;
    main_next.snap_pending = 1'h0;
    if (i_write_strobe) begin
      case (i_address)
        ADDR_RX_PORT: begin
          main_next.rx_port = i_write_data; // R1
        end
        ADDR_READBACK: begin
          main_next.readback     = i_write_data & READBACK_MASK; // R7
          main_next.snap_pending = 1'h1;
        end
        ADDR_POWER: begin
          main_next.power = i_write_data & POWER_MASK; // R11
        end
        default: begin
        end
      endcase
    end
    if (i_read_strobe) begin
      case (i_address)
        ADDR_RX_PORT:     main_next.read_data = main_reg.rx_port;
        ADDR_READBACK:    main_next.read_data = main_reg.readback;
        ADDR_POWER:       main_next.read_data = main_reg.power;
        ADDR_STATUS_VIEW: main_next.read_data = main_reg.status_hold;
        default:          main_next.read_data = 8'h00;
      endcase
    end
    if (main_reg.readback[CONTINUOUS_READBACK_BIT] || main_reg.snap_pending) begin // R7
      main_next.status_hold = status_pick(
        readback_sel_t'(main_reg.readback[SEL_HI:SEL_LO]),
        i_int_status, i_chan_status, i_spdif_status); // R5 R6
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      main_reg <= MAIN_RESET;
    end else begin
      main_reg <= main_next;
    end
  end

  assign o_read_data                = main_reg.read_data;
  assign o_rx_port_format           = port_format_t'(main_reg.rx_port[FMT_HI:FMT_LO]);
  assign o_rx_frame_polarity_select = main_reg.rx_port[POL_BIT];
  assign o_port_clock_master_select = main_reg.rx_port[MASTER_BIT];
  assign o_continuous_readback      = main_reg.readback[CONTINUOUS_READBACK_BIT];
  assign o_appended_flags_mode      = main_reg.readback[FLAGS_BIT]; // R8
  assign o_word_trunc_mask          = main_reg.readback[TRUNC_BIT]; // R9
  assign o_high_rate_rx_enable      = main_reg.readback[HIGH_RATE_BIT]; // R10
  assign o_pll_power_down           = main_reg.power[PLL_BIT]; // R11
  assign o_receiver_power_down      = main_reg.power[RX_PD_BIT]; // R11
  assign o_transmitter_power_down   = main_reg.power[TX_PD_BIT]; // R12
  assign o_status_view              = main_reg.status_hold;

  // crossings into and out of the link clock domain
  clock_sync #(.WIDTH(1)) reset_sync (
    .i_clock (i_link_clock),
    .i_data  (i_resetn),
    .o_data  (link_resetn)
  );

  clock_sync #(.WIDTH(6)) cfg_sync_inst (
    .i_clock (i_link_clock),
    .i_data  ({i_source_present, main_reg.rx_port[KEEP_BIT],
               main_reg.rx_port[MASTER_BIT], main_reg.rx_port[POL_BIT],
               main_reg.rx_port[FMT_HI:FMT_LO]}),
    .o_data  (cfg_sync)
  );

  clock_sync #(.WIDTH(1)) active_sync (
    .i_clock (i_clock),
    .i_data  (~link_reg.oe_n),
    .o_data  (o_port_clock_active)
  );

  assign cfg_fmt    = port_format_t'(cfg_sync[1:0]);
  assign cfg_pol    = cfg_sync[2];
  assign cfg_master = cfg_sync[3];
  assign cfg_keep   = cfg_sync[4];
  assign cfg_source = cfg_sync[5];
  assign run_ok     = cfg_master & (cfg_source | cfg_keep); // R3 R4
  assign frame_end  = link_reg.bit_div & link_reg.half & (link_reg.slot == SLOT_LAST);

  // port clock generator; a lost source waits for the frame end, slave mode releases at once
  always_comb begin
    link_next = link_reg;
    case (link_reg.state)
      LINK_IDLE: begin
        link_next.bit_div = 1'h0;
        link_next.slot    = SLOT_FIRST;
        link_next.half    = 1'h0;
        if (run_ok) begin
          link_next.state = LINK_RUN; // R3
        end
      end
      LINK_RUN, LINK_DRAIN: begin
        link_next.bit_div = ~link_reg.bit_div;
        if (link_reg.bit_div) begin
          link_next.slot = link_reg.slot + SLOT_STEP;
          if (link_reg.slot == SLOT_LAST) begin
            link_next.half = ~link_reg.half;
          end
        end
        if (run_ok) begin
          link_next.state = LINK_RUN; // R4
        end else if (!cfg_master) begin
          link_next.state = LINK_IDLE; // R3
        end else if (link_reg.state == LINK_RUN) begin
          link_next.state = LINK_DRAIN;
        end else if (frame_end) begin
          link_next.state = LINK_IDLE; // R4
        end
      end
      default: begin
        link_next.state = LINK_IDLE;
      end
    endcase
    link_active         = link_next.state != LINK_IDLE;
    link_next.oe_n      = ~link_active; // R3
    link_next.bit_out   = link_active & link_next.bit_div;
    link_next.frame_out = frame_level(cfg_fmt, cfg_pol, link_active,
                                      link_next.half, link_next.slot); // R1 R2
  end

  always_ff @(posedge i_link_clock) begin
    if (!link_resetn) begin
      link_reg <= LINK_RESET;
    end else begin
      link_reg <= link_next;
    end
  end

  assign o_bit_clock        = link_reg.bit_out;
  assign o_bit_clock_oe_n   = link_reg.oe_n;
  assign o_frame_clock      = link_reg.frame_out;
  assign o_frame_clock_oe_n = link_reg.oe_n;

  // checks on the system clock
  sequence rx_port_write_s;
    i_write_strobe && (i_address == ADDR_RX_PORT);
  endsequence

  sequence readback_write_s;
    i_write_strobe && (i_address == ADDR_READBACK);
  endsequence

  sequence power_write_s;
    i_write_strobe && (i_address == ADDR_POWER);
  endsequence

  property format_follows_p;
    @(posedge i_clock) disable iff (!i_resetn)
    rx_port_write_s |=> (o_rx_port_format == $past(i_write_data[FMT_HI:FMT_LO]))
                        && (o_rx_frame_polarity_select == $past(i_write_data[POL_BIT]));
  endproperty
  format_follow_a: assert property (format_follows_p) // R1
    else $error("format field did not follow the write");

  property reset_defaults_p;
    @(posedge i_clock)
    $rose(i_resetn) |-> o_pll_power_down && o_receiver_power_down
                        && o_high_rate_rx_enable && !o_port_clock_master_select;
  endproperty
  reset_defaults_a: assert property (reset_defaults_p) // R11
    else $error("control defaults wrong after reset");

  tx_power_a: assert property (@(posedge i_clock) disable iff (!i_resetn) // R12
    power_write_s |=> o_transmitter_power_down == $past(i_write_data[TX_PD_BIT]))
    else $error("transmitter power-down did not follow the write");

  mode_bits_a: assert property (@(posedge i_clock) disable iff (!i_resetn) // R8
    readback_write_s |=> (o_appended_flags_mode == $past(i_write_data[FLAGS_BIT]))
                         && (o_word_trunc_mask == $past(i_write_data[TRUNC_BIT]))
                         && (o_high_rate_rx_enable == $past(i_write_data[HIGH_RATE_BIT])))
    else $error("readback mode bits did not follow the write");

  select_snap_a: assert property (@(posedge i_clock) disable iff (!i_resetn) // R5
    (readback_write_s ##0 (i_write_data[SEL_HI:SEL_LO] == SEL_SPDIF)) ##1 !i_write_strobe
    |=> o_status_view == $past(i_spdif_status))
    else $error("selected status not captured after select write");

  continuous_readback_track_a: assert property (@(posedge i_clock) disable iff (!i_resetn) // R7
    (o_continuous_readback && (main_reg.readback[SEL_HI:SEL_LO] == SEL_INT)
     && !i_write_strobe) |=> o_status_view == $past(i_int_status))
    else $error("continuous readback did not track the status");

  // checks on the link clock
  slave_quiet_a: assert property (@(posedge i_link_clock) disable iff (!link_resetn) // R3
    !cfg_master |=> o_bit_clock_oe_n && o_frame_clock_oe_n)
    else $error("port clocks driven in slave mode");

  master_drive_a: assert property (@(posedge i_link_clock) disable iff (!link_resetn) // R3
    (run_ok && (link_reg.state == LINK_IDLE)) |=> !o_bit_clock_oe_n && !o_frame_clock_oe_n)
    else $error("master mode did not start driving the port clocks");

  keep_clock_a: assert property (@(posedge i_link_clock) disable iff (!link_resetn) // R4
    (cfg_master && cfg_keep && !cfg_source && (link_reg.state == LINK_RUN))
    |=> !o_bit_clock_oe_n)
    else $error("port clocks stopped although they should be kept");

  stop_bound_a: assert property (@(posedge i_link_clock) disable iff (!link_resetn) // R4
    (link_reg.state == LINK_DRAIN) |-> ##[0:130] ((link_reg.state == LINK_IDLE) || run_ok))
    else $error("port clocks did not stop after the source was lost");

  frame_pol_a: assert property (@(posedge i_link_clock) disable iff (!link_resetn) // R2
    (!o_frame_clock_oe_n && !is_dsp(cfg_fmt) && $stable(cfg_sync))
    |-> o_frame_clock == (link_reg.half ^ cfg_pol))
    else $error("frame clock polarity wrong");

  dsp_mode_b_a: assert property (@(posedge i_link_clock) disable iff (!link_resetn) // R2
    (!o_frame_clock_oe_n && is_dsp(cfg_fmt) && cfg_pol && $stable(cfg_sync))
    |-> o_frame_clock == (!link_reg.half && (link_reg.slot == SLOT_FIRST)))
    else $error("dsp sub-mode b frame pulse misplaced");

endmodule : spdif_rx_port_regs

// >>> testbench/host_port_model.sv
// host audio processor model watching the receive port clock pins
// assumes bit and frame clocks come from the device on the link clock
`timescale 1ns/100ps
module host_port_model (
  input  wire logic        i_link_clock,
  input  wire logic        i_bit_clock,
  input  wire logic        i_bit_clock_oe_n,
  input  wire logic        i_frame_clock,
  output logic [63:0]      o_frame_seen,
  output logic             o_frame_done,
  output logic [7:0]       o_period_errors
);
  logic       bit_prev;
  logic [7:0] gap;
  int         slot;

  initial begin
    bit_prev        = 1'b0;
    gap             = 8'h00;
    slot            = 0;
    o_frame_seen    = '0;
    o_frame_done    = 1'b0;
    o_period_errors = 8'h00;
  end

  // released pins: the host counts nothing until the device drives again
  always @(posedge i_link_clock) begin
    bit_prev <= i_bit_clock;
    if (i_bit_clock_oe_n) begin
      slot         <= 0;
      gap          <= 8'h00;
      o_frame_done <= 1'b0;
    end else begin
      gap <= gap + 8'h01;
      if (i_bit_clock && !bit_prev && slot < 64) begin
        gap <= 8'h01;
        if (slot > 0 && gap != 8'h02) begin
          o_period_errors <= o_period_errors + 8'h01;
        end
        o_frame_seen[slot[5:0]] <= i_frame_clock;
        slot                    <= slot + 1;
        o_frame_done            <= (slot == 63);
      end
    end
  end
endmodule : host_port_model

// >>> testbench/tb_spdif_rx_port_regs.sv
// self-checking bench of the receive port control registers
// assumes the host model file is compiled before this one
`timescale 1ns/100ps
module tb_spdif_rx_port_regs;
  import spdif_rx_port_pkg::*;
  logic         i_clock, i_resetn, i_link_clock, i_write_strobe, i_read_strobe;
  addr_t        i_address;
  byte_t        i_write_data, o_read_data, i_int_status, i_spdif_status, o_status_view;
  byte_t [4:0]  i_chan_status;
  logic         i_source_present;
  port_format_t o_rx_port_format;
  logic         o_rx_frame_polarity_select, o_port_clock_master_select;
  logic         o_continuous_readback, o_appended_flags_mode, o_word_trunc_mask;
  logic         o_high_rate_rx_enable, o_pll_power_down, o_receiver_power_down;
  logic         o_transmitter_power_down, o_port_clock_active;
  logic         o_bit_clock, o_bit_clock_oe_n, o_frame_clock, o_frame_clock_oe_n;
  logic [63:0]  frame_seen;
  logic         frame_done;
  logic [7:0]   period_errors;
  byte_t        d, e;
  int           errors = 0;
  int           checks = 0;

  spdif_rx_port_regs dut (.i_clock, .i_resetn, .i_link_clock, .i_address, .i_write_data,
    .i_write_strobe, .i_read_strobe, .o_read_data, .i_int_status, .i_chan_status,
    .i_spdif_status, .i_source_present, .o_rx_port_format, .o_rx_frame_polarity_select,
    .o_port_clock_master_select, .o_continuous_readback, .o_appended_flags_mode,
    .o_word_trunc_mask, .o_high_rate_rx_enable, .o_pll_power_down, .o_receiver_power_down,
    .o_transmitter_power_down, .o_status_view, .o_port_clock_active, .o_bit_clock,
    .o_bit_clock_oe_n, .o_frame_clock, .o_frame_clock_oe_n);

  host_port_model host (.i_link_clock, .i_bit_clock(o_bit_clock),
    .i_bit_clock_oe_n(o_bit_clock_oe_n), .i_frame_clock(o_frame_clock),
    .o_frame_seen(frame_seen), .o_frame_done(frame_done), .o_period_errors(period_errors));

  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  initial begin
    i_link_clock = 1'b0;
    #7;
    forever #24 i_link_clock = ~i_link_clock;
  end

  task automatic final_report;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  task automatic check_byte(input byte_t got, input byte_t exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_byte

  task automatic wr(input addr_t a, input byte_t v);
    @(posedge i_clock);
    i_address      <= a;
    i_write_data   <= v;
    i_write_strobe <= 1'b1;
    @(posedge i_clock);
    i_write_strobe <= 1'b0;
    #1;
  endtask : wr

  // read data stands in the cycle after the strobe only, zero after
  task automatic rd(input addr_t a, input byte_t mask, input byte_t exp);
    @(posedge i_clock);
    i_address     <= a;
    i_read_strobe <= 1'b1;
    @(posedge i_clock);
    i_read_strobe <= 1'b0;
    #1;
    check_byte(o_read_data & mask, exp);
    @(posedge i_clock);
    #1;
    check_byte(o_read_data, 8'h00);
  endtask : rd

  task automatic shuffle;
    @(posedge i_clock);
    i_int_status   <= byte_t'($urandom);
    i_spdif_status <= byte_t'($urandom);
    for (int k = 0; k < 5; k++) i_chan_status[k] <= byte_t'($urandom);
  endtask : shuffle

  task automatic wait_oe(input logic lvl);
    for (int n = 0; n < 400 && o_bit_clock_oe_n !== lvl; n++) begin
      @(posedge i_clock);
      #1;
    end
    check_byte({7'h0, o_bit_clock_oe_n}, {7'h0, lvl});
  endtask : wait_oe

  function automatic byte_t exp_view(input logic [2:0] s);
    if (s == 3'h0) return i_int_status;
    if (s == 3'h6) return i_spdif_status;
    if (s == 3'h7) return 8'h00;
    return i_chan_status[s - 3'h1];
  endfunction : exp_view

  function automatic logic exp_frame(input logic [1:0] fmt, input logic pol, input int k);
    if (fmt == 2'h3) return pol ? (k == 0) : (k == 63);
    return (k >= 32) ^ pol;
  endfunction : exp_frame

  initial begin
    #1000000;
    errors++;
    final_report();
  end

  initial begin
    i_resetn = 1'b0;
    i_address = '0;
    i_write_data = '0;
    i_write_strobe = 1'b0;
    i_read_strobe = 1'b0;
    i_int_status = '0;
    i_chan_status = '0;
    i_spdif_status = '0;
    i_source_present = 1'b0;
    void'($urandom(32'ha97d_6922));
    repeat (5) @(posedge i_clock);
    i_resetn <= 1'b1;
    #1;
    check_byte({o_high_rate_rx_enable, o_word_trunc_mask, o_appended_flags_mode,
      o_continuous_readback, o_port_clock_master_select, o_rx_frame_polarity_select,
      o_rx_port_format}, 8'h82);
    check_byte({5'h0, o_transmitter_power_down, o_receiver_power_down, o_pll_power_down},
      POWER_RESET);
    rd(ADDR_RX_PORT, 8'he3, 8'h02);
    rd(ADDR_READBACK, 8'hff, READBACK_RESET);
    rd(ADDR_POWER, 8'hff, POWER_RESET);
    rd(7'h00, 8'hff, 8'h00);
    repeat (12) begin
      d = byte_t'($urandom);
      wr(ADDR_RX_PORT, d & 8'hbf);
      wr(ADDR_READBACK, d);
      wr(ADDR_POWER, ~d);
      wr(7'h7f, ~d);
      wr(ADDR_STATUS_VIEW, ~d);
      check_byte({o_high_rate_rx_enable, o_word_trunc_mask, 1'b0, o_appended_flags_mode,
        o_continuous_readback, 3'h0}, d & 8'hd8);
      check_byte({2'h0, o_rx_frame_polarity_select, 3'h0, o_rx_port_format},
        d & 8'h23);
      check_byte({5'h0, o_transmitter_power_down, o_receiver_power_down, o_pll_power_down},
        ~d & POWER_MASK);
      rd(ADDR_RX_PORT, 8'he3, d & 8'ha3);
      rd(ADDR_READBACK, 8'hff, d & READBACK_MASK);
      rd(ADDR_POWER, 8'hff, ~d & POWER_MASK);
      rd(7'h7f, 8'hff, 8'h00);
    end
    for (int s = 0; s < 7; s++) begin
      shuffle();
      wr(ADDR_READBACK, {5'h0, s[2:0]});
      repeat (2) @(posedge i_clock);
      #1;
      e = exp_view(s[2:0]);
      check_byte(o_status_view, e);
      shuffle();
      repeat (3) @(posedge i_clock);
      rd(ADDR_STATUS_VIEW, 8'hff, e);
      wr(ADDR_READBACK, {5'h1, s[2:0]});
      shuffle();
      repeat (2) @(posedge i_clock);
      #1;
      check_byte(o_status_view, exp_view(s[2:0]));
    end
    for (int f = 0; f < 8; f++) begin
      wr(ADDR_RX_PORT, {2'b01, f[0], 3'h0, f[2:1]});
      @(posedge i_clock);
      i_source_present <= 1'b1;
      for (int n = 0; n < 600 && frame_done !== 1'b1; n++) @(posedge i_clock);
      #1;
      check_byte({6'h0, frame_done, o_frame_clock_oe_n}, 8'h02);
      check_byte({7'h0, o_port_clock_active}, 8'h01);
      for (int k = 0; k < 64; k++) begin
        check_byte({7'h0, frame_seen[k]}, {7'h0, exp_frame(f[2:1], f[0], k)});
      end
      @(posedge i_clock);
      i_source_present <= 1'b0;
      wait_oe(1'b1);
      repeat (10) @(posedge i_clock);
      #1;
      check_byte({6'h0, o_frame_clock_oe_n, o_frame_clock},
        {7'h01, f[2:1] != 2'h3 && f[0]});
    end
    wr(ADDR_RX_PORT, 8'hc2);
    wait_oe(1'b0);
    wr(ADDR_RX_PORT, 8'h02);
    wait_oe(1'b1);
    @(posedge i_clock);
    i_source_present <= 1'b1;
    repeat (300) @(posedge i_clock);
    #1;
    check_byte({6'h0, o_bit_clock_oe_n, o_port_clock_active}, 8'h02);
    check_byte(period_errors, 8'h00);
    final_report();
  end
endmodule : tb_spdif_rx_port_regs
